// ### hdl/wcf_watch_ctrl.v
// comparator zero function control with axi4-lite registers
//
// The implementer's own choices: the AXI4-Lite register port and the register offsets.
`include "wcf_consts.vh"
`default_nettype none
// Notes on behaviour
// - reserved function register bits read zero
// - link number field holds only zero or one
// - data match uses comparator one for address when linked to it; a self link checks no address
// - size field picks byte, halfword or word
// - bit eight selects address or data compare
// - comparator zero address/data; comparator one address
// - action field: off, fetch, operand read
// - action six watches operand writes only
// - action seven watches reads and writes; other codes reserved, never match
// - comparator one mask widens linked range
// - match flag sticky, cleared by register read
module wcf_watch_ctrl (
	input wire clk,
	input wire reset,
	input wire [3:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [3:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire bus_valid,
	input wire [1:0] bus_kind,
	input wire [31:0] bus_addr,
	input wire [31:0] bus_data,
	input wire [31:0] comparator1_reference,
	input wire [4:0] comparator1_range_mask,
	input wire [4:0] comparator0_range_mask,
	output reg comparator0_hit,
	output wire irq
);
	// held function register fields
	reg [3:0] action_r;
	reg data_value_match_select_r;
	reg [1:0] data_compare_size_r;
	reg linked_comparator_number_r;
	reg match_flag_r;
	reg [31:0] comparator0_reference_r;
	reg [31:0] irq_status_r;
	reg [31:0] irq_mask_r;
	// write channel holding
	reg aw_full_r;
	reg [3:0] aw_addr_r;
	reg w_full_r;
	reg [31:0] w_data_r;
	reg [3:0] w_strb_r;
	// register stage on the watched bus (same clock domain as the core)
	reg bus_valid_r;
	reg [1:0] bus_kind_r;
	reg [31:0] bus_addr_r;
	reg [31:0] bus_data_r;

	wire [31:0] fct0_read;
	wire write_go;
	wire read_go;
	wire fct0_read_go;
	wire kind_ok;
	wire addr0_hit;
	wire addr1_hit;
	wire data0_hit;
	wire link_addr_hit;
	wire match_event;
	wire [31:0] w_merged;
	wire [31:0] fct0_next;

	function [31:0] merge_strb;
		input [31:0] old_val;
		input [31:0] new_val;
		input [3:0] strb;
		integer b;
		begin
			merge_strb = old_val;
			for (b = 0; b < 4; b = b + 1) begin
				if (strb[b])
					merge_strb[b*8 +: 8] = new_val[b*8 +: 8];
			end
		end
	endfunction

	function addr_is_mapped;
		input [3:0] a;
		begin
			addr_is_mapped = (a == `WCF_OFS_FCT0) || (a == `WCF_OFS_COMP0) ||
				(a == `WCF_OFS_IRQ_STATUS) || (a == `WCF_OFS_IRQ_MASK);
		end
	endfunction

	// reserved ranges 31:25, 23:16, 9 and 7:4 are constant zero
	assign fct0_read = {7'h00, match_flag_r, 4'h0, 4'h0,
		3'h0, linked_comparator_number_r, data_compare_size_r, 1'b0,
		data_value_match_select_r, 4'h0, action_r};

	// write path
	assign s_axi_awready = !aw_full_r && !s_axi_bvalid;
	assign s_axi_wready = !w_full_r && !s_axi_bvalid;
	assign write_go = aw_full_r && w_full_r && !s_axi_bvalid;
	assign w_merged = merge_strb(fct0_read, w_data_r, w_strb_r);
	assign fct0_next = w_merged & `WCF_FCT0_WMASK;

	always @(posedge clk or posedge reset) begin
		if (reset) begin
			aw_full_r <= 1'b0;
			aw_addr_r <= 4'h0;
			w_full_r <= 1'b0;
			w_data_r <= 32'h0000_0000;
			w_strb_r <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `WCF_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_full_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_full_r <= 1'b1;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
			end
			if (write_go) begin
				aw_full_r <= 1'b0;
				w_full_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= addr_is_mapped(aw_addr_r) ? `WCF_RESP_OKAY : `WCF_RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// read path
	assign s_axi_arready = !s_axi_rvalid;
	assign read_go = s_axi_arvalid && s_axi_arready;
	assign fct0_read_go = read_go && (s_axi_araddr == `WCF_OFS_FCT0);

	always @(posedge clk or posedge reset) begin
		if (reset) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `WCF_RESP_OKAY;
		end else begin
			if (read_go) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= addr_is_mapped(s_axi_araddr) ? `WCF_RESP_OKAY : `WCF_RESP_SLVERR;
				case (s_axi_araddr)
					`WCF_OFS_FCT0: s_axi_rdata <= fct0_read;
					`WCF_OFS_COMP0: s_axi_rdata <= comparator0_reference_r;
					`WCF_OFS_IRQ_STATUS: s_axi_rdata <= irq_status_r;
					`WCF_OFS_IRQ_MASK: s_axi_rdata <= irq_mask_r;
					default: s_axi_rdata <= 32'h0000_0000;
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// register writes
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			action_r <= `WCF_ACT_OFF;
			data_value_match_select_r <= 1'b0;
			data_compare_size_r <= `WCF_SZ_BYTE;
			linked_comparator_number_r <= 1'b0;
			comparator0_reference_r <= 32'h0000_0000;
			irq_mask_r <= 32'h0000_0000;
		end else if (write_go) begin
			case (aw_addr_r)
				`WCF_OFS_FCT0: begin
					action_r <= fct0_next[`WCF_ACT_HI:`WCF_ACT_LO];
					data_value_match_select_r <= fct0_next[`WCF_DVM_BIT];
					data_compare_size_r <= fct0_next[`WCF_SIZE_HI:`WCF_SIZE_LO];
					// only the low bit is kept: any odd link value names comparator one
					linked_comparator_number_r <= fct0_next[`WCF_LINK_LO];
				end
				`WCF_OFS_COMP0: comparator0_reference_r <=
					merge_strb(comparator0_reference_r, w_data_r, w_strb_r);
				`WCF_OFS_IRQ_MASK: irq_mask_r <=
					merge_strb(irq_mask_r, w_data_r, w_strb_r) &
					(32'h0000_0001 << `WCF_IRQ_MATCH_BIT);
				default: ;
			endcase
		end
	end

	// watched access filter by action code
	assign kind_ok =
		(action_r == `WCF_ACT_FETCH && bus_kind_r == `WCF_KIND_FETCH) ||
		(action_r == `WCF_ACT_READ && bus_kind_r == `WCF_KIND_READ) ||
		(action_r == `WCF_ACT_WRITE && bus_kind_r == `WCF_KIND_WRITE) ||
		(action_r == `WCF_ACT_RW && (bus_kind_r == `WCF_KIND_READ ||
			bus_kind_r == `WCF_KIND_WRITE));
	// reserved action codes simply never match

	wcf_addr_cmp #(.AW(32)) u_addr0 (
		.addr(bus_addr_r),
		.ref_addr(comparator0_reference_r),
		.mask_bits(comparator0_range_mask),
		.fetch_mode(action_r == `WCF_ACT_FETCH),
		.hit(addr0_hit)
	);

	// comparator one's mask widens the linked address range
	wcf_addr_cmp #(.AW(32)) u_addr1 (
		.addr(bus_addr_r),
		.ref_addr(comparator1_reference),
		.mask_bits(comparator1_range_mask),
		.fetch_mode(1'b0),
		.hit(addr1_hit)
	);

	wcf_data_cmp u_data0 (
		.data(bus_data_r),
		.ref_data(comparator0_reference_r),
		.size(data_compare_size_r),
		.hit(data0_hit)
	);

	// comparator zero's own reference holds the data, so a self link cannot check address
	assign link_addr_hit = linked_comparator_number_r ? addr1_hit : 1'b1;
	assign match_event = bus_valid_r && kind_ok &&
		(data_value_match_select_r ? (data0_hit && link_addr_hit) : addr0_hit);

	always @(posedge clk or posedge reset) begin
		if (reset) begin
			bus_valid_r <= 1'b0;
			bus_kind_r <= `WCF_KIND_FETCH;
			bus_addr_r <= 32'h0000_0000;
			bus_data_r <= 32'h0000_0000;
			match_flag_r <= 1'b0;
			irq_status_r <= 32'h0000_0000;
			comparator0_hit <= 1'b0;
		end else begin
			bus_valid_r <= bus_valid;
			bus_kind_r <= bus_kind;
			bus_addr_r <= bus_addr;
			bus_data_r <= bus_data;
			comparator0_hit <= match_event;
			// a match in the reading cycle survives the clear
			if (match_event)
				match_flag_r <= 1'b1;
			else if (fct0_read_go)
				match_flag_r <= 1'b0;
			if (match_event)
				irq_status_r[`WCF_IRQ_MATCH_BIT] <= 1'b1;
			else if (write_go && aw_addr_r == `WCF_OFS_IRQ_STATUS &&
				w_strb_r[0] && w_data_r[`WCF_IRQ_MATCH_BIT])
				irq_status_r[`WCF_IRQ_MATCH_BIT] <= 1'b0;
		end
	end

	assign irq = |(irq_status_r & irq_mask_r);
endmodule // wcf_watch_ctrl
`default_nettype wire

// ### hdl/wcf_consts.vh
// constants for the comparator zero function control block
`ifndef WCF_CONSTS_VH
`define WCF_CONSTS_VH
// register byte offsets (no offsets printed; chosen locally)
`define WCF_OFS_FCT0 4'h0
`define WCF_OFS_COMP0 4'h4
`define WCF_OFS_IRQ_STATUS 4'h8
`define WCF_OFS_IRQ_MASK 4'hc
// field positions inside the function register
`define WCF_MATCH_BIT 24
`define WCF_LINK_HI 15
`define WCF_LINK_LO 12
`define WCF_SIZE_HI 11
`define WCF_SIZE_LO 10
`define WCF_DVM_BIT 8
`define WCF_ACT_HI 3
`define WCF_ACT_LO 0
// writable bits of the function register
`define WCF_FCT0_WMASK 32'h0000_fd0f
`define WCF_FCT0_RESET 32'h0000_0000
// action codes
`define WCF_ACT_OFF 4'h0
`define WCF_ACT_FETCH 4'h4
`define WCF_ACT_READ 4'h5
`define WCF_ACT_WRITE 4'h6
`define WCF_ACT_RW 4'h7
// data size codes
`define WCF_SZ_BYTE 2'h0
`define WCF_SZ_HALF 2'h1
`define WCF_SZ_WORD 2'h2
// bus access kinds from the core
`define WCF_KIND_FETCH 2'h0
`define WCF_KIND_READ 2'h1
`define WCF_KIND_WRITE 2'h2
// axi responses
`define WCF_RESP_OKAY 2'h0
`define WCF_RESP_SLVERR 2'h2
// interrupt event bit for comparator zero match
`define WCF_IRQ_MATCH_BIT 0
`endif

// ### hdl/wcf_addr_cmp.v
// masked address comparator, used for either comparator's address side
`default_nettype none
module wcf_addr_cmp #(
	parameter AW = 32
) (
	input wire [AW-1:0] addr,
	input wire [AW-1:0] ref_addr,
	input wire [4:0] mask_bits,
	input wire fetch_mode,
	output wire hit
);
	reg [AW-1:0] care;
	integer i;
	always @* begin
		care = {AW{1'b1}};
		// mask zero on a fetch still ignores bit 0: fetches are halfword aligned
		for (i = 0; i < AW; i = i + 1) begin
			if (i < mask_bits)
				care[i] = 1'b0;
		end
		if (mask_bits == 5'h00 && fetch_mode)
			care[0] = 1'b0;
	end
	assign hit = ((addr ^ ref_addr) & care) == {AW{1'b0}};
endmodule // wcf_addr_cmp
`default_nettype wire

// ### hdl/wcf_data_cmp.v
// data value comparator with byte, halfword and word sizes
`include "wcf_consts.vh"
`default_nettype none
module wcf_data_cmp (
	input wire [31:0] data,
	input wire [31:0] ref_data,
	input wire [1:0] size,
	output reg hit
);
	// reference is replicated across lanes by software, so the low lanes suffice
	always @* begin
		case (size)
			`WCF_SZ_BYTE: hit = data[7:0] == ref_data[7:0];
			`WCF_SZ_HALF: hit = data[15:0] == ref_data[15:0];
			`WCF_SZ_WORD: hit = data == ref_data;
			default: hit = 1'b0;
		endcase
	end
endmodule // wcf_data_cmp
`default_nettype wire

// ### bench/wcf_watch_ctrl_asserts.sv
// port checker for the comparator zero function control block
`include "wcf_consts.vh"
`default_nettype none
module wcf_watch_ctrl_asserts (
	input wire logic clk,
	input wire logic reset,
	input wire logic s_axi_awready,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic bus_valid,
	input wire logic comparator0_hit,
	input wire logic irq
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	logic [3:0] ra_r;
	// address of the read in flight, so read data can be judged per register
	always_ff @(posedge clk or posedge reset) begin
		if (reset) ra_r <= 4'h0;
		else if (s_axi_arvalid && s_axi_arready) ra_r <= s_axi_araddr;
	end
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered");
	a_ar_block: assert property (s_axi_arready == !s_axi_rvalid) else $error("arready wrong");
	a_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken under response");
	a_hit_cause: assert property (comparator0_hit |-> $past(bus_valid, 2))
		else $error("hit without access");
	a_rsv_zero: assert property (s_axi_rvalid && ra_r == 4'h0 |->
		(s_axi_rdata & 32'hfeff_02f0) == 32'h0) else $error("reserved bits set");
	a_link_range: assert property (s_axi_rvalid && ra_r == 4'h0 |->
		s_axi_rdata[15:13] == 3'h0) else $error("link number above one");
	a_bad_addr: assert property (s_axi_rvalid && ra_r[1:0] != 2'h0 |->
		s_axi_rresp == `WCF_RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read");
	c_hit: cover property (comparator0_hit);
	c_irq: cover property (irq);
	c_slverr: cover property (s_axi_rvalid && s_axi_rresp == `WCF_RESP_SLVERR);
endmodule // wcf_watch_ctrl_asserts
bind wcf_watch_ctrl wcf_watch_ctrl_asserts u_chk (.clk(clk), .reset(reset),
	.s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.bus_valid(bus_valid), .comparator0_hit(comparator0_hit), .irq(irq));
`default_nettype wire

// ### bench/wcf_core_model.sv
// model of the watched core bus
`default_nettype none
module wcf_core_model (
	input wire logic clk,
	output logic bus_valid,
	output logic [1:0] bus_kind,
	output logic [31:0] bus_addr,
	output logic [31:0] bus_data
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		bus_valid = 1'b0;
		bus_kind = 2'h0;
		bus_addr = 32'h0;
		bus_data = 32'h0;
	end
	task access(input logic [1:0] k, input logic [31:0] a, input logic [31:0] d);
		@(posedge clk);
		bus_valid <= 1'b1;
		bus_kind <= k;
		bus_addr <= a;
		bus_data <= d;
		@(posedge clk);
		bus_valid <= 1'b0;
		// idle lines flip so a stale value can never pass for a match
		bus_addr <= ~a;
		bus_data <= ~d;
	endtask
endmodule // wcf_core_model
`default_nettype wire

// ### bench/wcf_watch_ctrl_bench.sv
// self-checking bench for the comparator zero function control block
`include "wcf_consts.vh"
`default_nettype none
module wcf_watch_ctrl_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, reset = 1, awv = 0, wv = 0, brdy = 0, arv = 0, rrdy = 0;
	logic [3:0] awa = 0, ara = 0;
	logic [31:0] wd = 0, c1_ref = 0, d;
	logic [4:0] c1_mask = 0;
	logic [1:0] r;
	wire awr, wr_rdy, bv, arr, rv, hit, irq, cv;
	wire [1:0] br, rr, ck;
	wire [31:0] rdat, ca, cd;
	int fails = 0, comparisons = 0, cyc = 0;
	int hits = 0;
	logic [3:0] codes [5] = '{`WCF_ACT_OFF, `WCF_ACT_FETCH, `WCF_ACT_READ, `WCF_ACT_WRITE,
		`WCF_ACT_RW};
	logic [31:0] dv [3] = '{32'hffff_ffa5, 32'hffff_56a5, 32'h1234_56a5};
	wcf_core_model core (.clk(clk), .bus_valid(cv), .bus_kind(ck), .bus_addr(ca), .bus_data(cd));
	wcf_watch_ctrl uut (.clk(clk), .reset(reset), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
		.s_axi_wready(wr_rdy), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(brdy),
		.s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
		.s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rrdy), .bus_valid(cv),
		.bus_kind(ck), .bus_addr(ca), .bus_data(cd), .comparator1_reference(c1_ref),
		.comparator1_range_mask(c1_mask), .comparator0_range_mask(5'h0),
		.comparator0_hit(hit), .irq(irq));
	always #5 clk = ~clk;
	// comparator0_hit is a one-cycle pulse, so it is counted rather than sampled
	always @(posedge clk) begin
		if (hit === 1'b1) hits++;
	end
	task results;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// ceiling well above the few hundred cycles the tests need
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			results;
		end
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task wr(input logic [3:0] a, input logic [31:0] v);
		@(posedge clk);
		awa <= a;
		wd <= v;
		awv <= 1'b1;
		wv <= 1'b1;
		brdy <= 1'b1;
		do begin
			@(posedge clk);
			if (awr) awv <= 1'b0;
			if (wr_rdy) wv <= 1'b0;
		end while (!bv);
		brdy <= 1'b0;
		chk(br, `WCF_RESP_OKAY);
	endtask
	task rd(input logic [3:0] a);
		@(posedge clk);
		ara <= a;
		arv <= 1'b1;
		rrdy <= 1'b1;
		do begin
			@(posedge clk);
			if (arr) arv <= 1'b0;
		end while (!rv);
		d = rdat;
		r = rr;
		rrdy <= 1'b0;
	endtask
	task flag(input logic e);
		rd(`WCF_OFS_FCT0);
		chk(d[`WCF_MATCH_BIT], e);
	endtask
	task t_regs;
		rd(`WCF_OFS_FCT0);
		chk(d, `WCF_FCT0_RESET);
		rd(`WCF_OFS_IRQ_MASK);
		chk(d, 32'h0);
		wr(`WCF_OFS_FCT0, 32'hffff_ffff);
		rd(`WCF_OFS_FCT0);
		chk(d, 32'h0000_1d0f);
		rd(4'h2);
		chk(r, `WCF_RESP_SLVERR);
		$display("test regs done");
	endtask
	task t_actions;
		logic e;
		wr(`WCF_OFS_COMP0, 32'h0000_1000);
		for (int i = 0; i < 5; i++) begin
			wr(`WCF_OFS_FCT0, {28'h0, codes[i]});
			for (int k = 0; k < 3; k++) begin
				e = (i == 1 && k == 0) || (i == 2 && k == 1) || (i == 3 && k == 2) || (i == 4 && k != 0);
				core.access(k[1:0], 32'h0000_1000, 32'h0);
				flag(e);
			end
		end
		flag(1'b0);
		core.access(`WCF_KIND_WRITE, 32'h0000_1004, 32'h0);
		flag(1'b0);
		chk(hits, 32'd5);
		$display("test actions done");
	endtask
	task t_sizes;
		wr(`WCF_OFS_COMP0, 32'h1234_56a5);
		for (int s = 0; s < 3; s++) begin
			wr(`WCF_OFS_FCT0, 32'h0000_0106 | (s << 10));
			for (int j = 0; j < 3; j++) begin
				core.access(`WCF_KIND_WRITE, 32'h9999_0000, dv[j]);
				flag(s <= j);
			end
		end
		$display("test sizes done");
	endtask
	task t_link;
		c1_ref <= 32'h2000_0000;
		c1_mask <= 5'd4;
		wr(`WCF_OFS_FCT0, 32'h0000_1906);
		core.access(`WCF_KIND_WRITE, 32'h2000_000c, 32'h1234_56a5);
		flag(1'b1);
		core.access(`WCF_KIND_WRITE, 32'h2000_0010, 32'h1234_56a5);
		flag(1'b0);
		$display("test link done");
	endtask
	task t_irq;
		// earlier matches left the status bit set; clear it so the new event is seen
		wr(`WCF_OFS_IRQ_STATUS, 32'h1);
		rd(`WCF_OFS_IRQ_STATUS);
		chk(d, 32'h0);
		core.access(`WCF_KIND_WRITE, 32'h2000_0004, 32'h1234_56a5);
		rd(`WCF_OFS_IRQ_STATUS);
		chk(d, 32'h1);
		chk(irq, 1'b0);
		wr(`WCF_OFS_IRQ_MASK, 32'h1);
		chk(irq, 1'b1);
		wr(`WCF_OFS_IRQ_STATUS, 32'h1);
		chk(irq, 1'b0);
		rd(`WCF_OFS_IRQ_STATUS);
		chk(d, 32'h0);
		$display("test irq done");
	endtask
	initial begin
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		t_regs;
		t_actions;
		t_sizes;
		t_link;
		t_irq;
		results;
	end
endmodule // wcf_watch_ctrl_bench
`default_nettype wire
